// ===== shp_pkg.sv
// Purpose: Shared constants for the sensor host serial slave port.
// Assumes: 250 MHz core clock; host clock is sampled, not used as a clock.
// Notes: Overview list below gives the behaviour the port keeps.
//
// Overview of operation
// - SEL high gives I2C, low gives SPI
// - CS strap picks address 0x9E or 0xA0
// - Address byte: seven bits then direction bit
// - Eight data bits then one acknowledge pulse
// - Clock pin is input only, never driven
// - Data line open-drain: pull low or release
// - Works with serial clock up to 400 kHz
// - START/STOP: data edge while clock high
// - Repeated START keeps frame, expects new address
// - STOP ends frame anywhere except START pulse
// - Receiver holds data low through ninth pulse
// - Read bytes shifted out, nine pulses each
// - Final read byte NACKed, device releases data
// - SPI selected only while CS low, else Hi-Z
// - Lines idle high; release when not driving
// - Pointer advances after each written byte
// - Fresh START plus read resets pointer zero
// - Pointer saturates at top register address
package shp_pkg;
    localparam int DATA_W = 8;
    localparam logic [6:0] ADDR_STRAP_LO = 7'h4F;
    localparam logic [6:0] ADDR_STRAP_HI = 7'h50;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] PTR_TOP = 8'hFF;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int CLK_MHZ = 250;
    localparam int SCL_MAX_KHZ = 400;
    // Shortest host clock period in core cycles, rounded down
    localparam int SCL_MIN_PERIOD_CYC = (CLK_MHZ * 1000) / SCL_MAX_KHZ;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RX = 5'b00010,
        ST_RACK = 5'b00100,
        ST_TX = 5'b01000,
        ST_MACK = 5'b10000
    } shp_state_e;

    typedef enum logic [1:0] {
        BK_ADDR = 2'b00,
        BK_PTR = 2'b01,
        BK_DATA = 2'b10
    } shp_kind_e;
endpackage

// ===== shp_i2c_slave_port.sv
// Purpose: Host-side serial slave port; I2C framing and register access.
// Assumes: reg_rdata shows the register at reg_addr, same clock, no wait.
// Notes: SPI word format is outside this block; only select and Hi-Z kept.
`timescale 1ns/100ps
`default_nettype none
module shp_i2c_slave_port (
    input wire logic clk,
    input wire logic rst,
    input wire logic sel_pin,
    input wire logic cs_n_pin,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic spi_dout,
    output logic spi_dout_oe,
    output logic spi_selected,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_we,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // ****************************************
    // Input synchronisers and edge detection
    // ****************************************
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic sel_m, sel_s, cs_m, cs_s;
    logic scl_rise, scl_fall, start_det, stop_raw, stop_det, start_hi;

    // Host clock is only sampled, never driven; 400 kHz leaves hundreds of cycles per phase
    always_ff @(posedge clk) begin
        if (rst) begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
            {sel_m, sel_s, cs_m, cs_s} <= 4'hF;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_d <= sda_s;
            sel_m <= sel_pin;
            sel_s <= sel_m;
            cs_m <= cs_n_pin;
            cs_s <= cs_m;
        end
    end

    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_det = sel_s & scl_s & scl_d & sda_d & ~sda_s;
    assign stop_raw = sel_s & scl_s & scl_d & ~sda_d & sda_s;
    assign stop_det = stop_raw & ~start_hi;

    // A STOP in the same clock-high interval as the START is not honoured
    always_ff @(posedge clk) begin
        if (rst) begin
            start_hi <= 1'b0;
        end else if (start_det) begin
            start_hi <= 1'b1;
        end else if (scl_fall) begin
            start_hi <= 1'b0;
        end
    end

    // ****************************************
    // Pointer helper
    // ****************************************
    function automatic logic [7:0] sat_inc(input logic [7:0] p);
        sat_inc = (p == shp_pkg::PTR_TOP) ? p : p + 8'h01;
    endfunction

    // ****************************************
    // I2C protocol engine
    // ****************************************
    shp_pkg::shp_state_e state;
    shp_pkg::shp_kind_e kind;
    logic [7:0] rx_sh, tx_sh;
    logic [3:0] bit_cnt;
    logic rw_read, busy, fresh, mack;
    logic [6:0] my_addr;

    assign my_addr = cs_s ? shp_pkg::ADDR_STRAP_HI : shp_pkg::ADDR_STRAP_LO;

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= shp_pkg::ST_IDLE;
            kind <= shp_pkg::BK_ADDR;
            rx_sh <= 8'h00;
            tx_sh <= 8'h00;
            bit_cnt <= 4'h0;
            rw_read <= 1'b0;
            busy <= 1'b0;
            fresh <= 1'b0;
            mack <= 1'b0;
            sda_oe <= 1'b0;
            reg_addr <= shp_pkg::PTR_RESET;
            reg_wdata <= 8'h00;
            reg_we <= 1'b0;
            reg_rd <= 1'b0;
        end else begin
            reg_rd <= 1'b0;
            reg_we <= 1'b0;
            if (reg_we) begin
                reg_addr <= sat_inc(reg_addr);
            end
            if (!sel_s) begin
                state <= shp_pkg::ST_IDLE;
                busy <= 1'b0;
                sda_oe <= 1'b0;
            end else if (start_det) begin
                // Fresh address byte expected after any START
                state <= shp_pkg::ST_RX;
                kind <= shp_pkg::BK_ADDR;
                bit_cnt <= 4'h0;
                fresh <= ~busy;
                busy <= 1'b1;
                sda_oe <= 1'b0;
            end else if (stop_det) begin
                state <= shp_pkg::ST_IDLE;
                busy <= 1'b0;
                sda_oe <= 1'b0;
            end else begin
                unique case (state)
                    shp_pkg::ST_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    shp_pkg::ST_RX: begin
                        if (scl_rise) begin
                            rx_sh <= {rx_sh[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == shp_pkg::BITS_PER_BYTE) begin
                            bit_cnt <= 4'h0;
                            unique case (kind)
                                shp_pkg::BK_ADDR: begin
                                    if (rx_sh[7:1] == my_addr) begin
                                        rw_read <= rx_sh[0];
                                        sda_oe <= 1'b1;
                                        state <= shp_pkg::ST_RACK;
                                        kind <= shp_pkg::BK_PTR;
                                        if (rx_sh[0] && fresh) begin
                                            reg_addr <= shp_pkg::PTR_RESET;
                                        end
                                    end else begin
                                        state <= shp_pkg::ST_IDLE;
                                    end
                                end
                                shp_pkg::BK_PTR: begin
                                    reg_addr <= rx_sh;
                                    sda_oe <= 1'b1;
                                    state <= shp_pkg::ST_RACK;
                                    kind <= shp_pkg::BK_DATA;
                                end
                                default: begin
                                    reg_wdata <= rx_sh;
                                    reg_we <= 1'b1;
                                    sda_oe <= 1'b1;
                                    state <= shp_pkg::ST_RACK;
                                end
                            endcase
                        end
                    end
                    shp_pkg::ST_RACK: begin
                        if (scl_fall) begin
                            if (rw_read) begin
                                tx_sh <= reg_rdata;
                                sda_oe <= ~reg_rdata[7];
                                reg_rd <= 1'b1;
                                reg_addr <= sat_inc(reg_addr);
                                state <= shp_pkg::ST_TX;
                            end else begin
                                sda_oe <= 1'b0;
                                state <= shp_pkg::ST_RX;
                            end
                        end
                    end
                    shp_pkg::ST_TX: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt == shp_pkg::BITS_PER_BYTE) begin
                                sda_oe <= 1'b0;
                                bit_cnt <= 4'h0;
                                state <= shp_pkg::ST_MACK;
                            end else begin
                                tx_sh <= {tx_sh[6:0], 1'b0};
                                sda_oe <= ~tx_sh[6];
                            end
                        end
                    end
                    shp_pkg::ST_MACK: begin
                        if (scl_rise) begin
                            mack <= ~sda_s;
                        end else if (scl_fall) begin
                            if (mack) begin
                                tx_sh <= reg_rdata;
                                sda_oe <= ~reg_rdata[7];
                                reg_rd <= 1'b1;
                                reg_addr <= sat_inc(reg_addr);
                                state <= shp_pkg::ST_TX;
                            end else begin
                                // NACK: stay off the line until STOP or START
                                state <= shp_pkg::ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state <= shp_pkg::ST_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Open-drain: the data level is always low, only the enable moves
    always_ff @(posedge clk) begin
        if (rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // ****************************************
    // SPI select and output release
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            spi_selected <= 1'b0;
            spi_dout_oe <= 1'b0;
            spi_dout <= 1'b0;
        end else begin
            spi_selected <= ~sel_s & ~cs_s;
            spi_dout_oe <= ~sel_s & ~cs_s;
            spi_dout <= 1'b0;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_idle_release: assert property (
        state == shp_pkg::ST_IDLE && $past(state) == shp_pkg::ST_IDLE |-> !sda_oe)
        else $error("data line driven while idle");
    chk_spi_no_sda: assert property (!sel_s |=> !sda_oe)
        else $error("data line driven in SPI mode");
    chk_spi_hiz: assert property (cs_s |=> !spi_dout_oe)
        else $error("SPI output driven while deselected");
    chk_ack_hold: assert property (
        state == shp_pkg::ST_RACK && !stop_det && !start_det |=> sda_oe || !scl_d
        || state != shp_pkg::ST_RACK)
        else $error("acknowledge released early");
    chk_ptr_write: assert property (
        reg_we |=> reg_addr == sat_inc($past(reg_addr)))
        else $error("pointer did not advance after write");
    chk_ptr_sat: assert property (
        reg_rd && $past(reg_addr) == shp_pkg::PTR_TOP |-> reg_addr == shp_pkg::PTR_TOP)
        else $error("pointer wrapped past top");
    chk_start_addr: assert property (
        start_det |=> state == shp_pkg::ST_RX && kind == shp_pkg::BK_ADDR && bit_cnt == 4'h0)
        else $error("START did not restart address phase");
    chk_stop_end: assert property (
        stop_det |=> state == shp_pkg::ST_IDLE ##1 !sda_oe[*2])
        else $error("STOP did not end frame");
    chk_drive_scl_low: assert property ($rose(sda_oe) |-> !scl_s)
        else $error("data line pulled while clock high");
    chk_read_reset: assert property (
        state == shp_pkg::ST_RX && kind == shp_pkg::BK_ADDR && scl_fall && fresh
        && bit_cnt == shp_pkg::BITS_PER_BYTE && rx_sh == {my_addr, 1'b1} && sel_s
        && !start_det && !stop_det |=> reg_addr == shp_pkg::PTR_RESET)
        else $error("fresh read did not reset pointer");

    cov_write_byte: cover property (reg_we);
    cov_read_byte: cover property (reg_rd ##[1:1000] reg_rd);
    cov_rep_start: cover property (start_det && busy);
    cov_nack_end: cover property (state == shp_pkg::ST_MACK && scl_fall && !mack);
endmodule
`default_nettype wire

// ===== shp_host_model.sv
// Purpose: Behavioural bus master that drives the host clock and pulls the data wire.
// Assumes: 250 MHz bench clock; one host clock bit takes 40 core cycles (160 ns).
// Notes: The master only ever pulls the data wire low; the pull-up gives the high level.
`timescale 1ns/100ps
`default_nettype none
module shp_host_model (
    input wire logic clk,
    input wire logic sda_wire,
    output logic scl,
    output logic pull
);
    // ************************************************************
    // Bus conditions and bit slots
    // ************************************************************
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Only this model moves the host clock
    task automatic start_cond();
        pull <= 1'b0;
        wait_clk(10);
        scl <= 1'b1;
        wait_clk(10);
        pull <= 1'b1;
        wait_clk(10);
        scl <= 1'b0;
        wait_clk(10);
    endtask

    // A STOP always gets a clock-high phase of its own
    task automatic stop_cond();
        pull <= 1'b1;
        wait_clk(10);
        scl <= 1'b1;
        wait_clk(10);
        pull <= 1'b0;
        wait_clk(20);
    endtask

    // 160 ns per bit runs at 6.25 MHz, far above the 400 kHz ceiling
    task automatic bit_xfer(input logic b, output logic r);
        pull <= ~b;
        wait_clk(10);
        scl <= 1'b1;
        wait_clk(10);
        @(negedge clk);
        r = sda_wire;
        wait_clk(10);
        scl <= 1'b0;
        wait_clk(10);
    endtask

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
        end
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask

    task automatic read_byte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, r);
            d[i] = r;
        end
        bit_xfer(~mack, r);
    endtask
endmodule
`default_nettype wire

// ===== tb.sv
// Purpose: Self-checking bench for the host serial slave port.
// Assumes: Register file lives here and answers reg_addr in the same cycle.
// Notes: Strap and mode pins change only between frames.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk, rst, sel_pin, cs_n_pin, scl, pull, sda_oe, sda_out, sda_wire;
    logic spi_dout, spi_dout_oe, spi_selected, reg_we, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [7:0] regs [256];
    int n_errors = 0;
    int checked = 0;

    // ************************************************************
    // Wiring, register file and clock
    // ************************************************************
    assign sda_wire = (sda_oe ? sda_out : 1'b1) & ~pull;
    assign reg_rdata = regs[reg_addr];
    always @(posedge clk) if (reg_we) regs[reg_addr] <= reg_wdata;

    shp_i2c_slave_port shp_i2c_slave_port_i (.clk(clk), .rst(rst), .sel_pin(sel_pin),
        .cs_n_pin(cs_n_pin), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe(sda_oe), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe),
        .spi_selected(spi_selected), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    shp_host_model shp_host_model_i (.clk(clk), .sda_wire(sda_wire), .scl(scl), .pull(pull));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (n_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        checked++;
        if (!ok) begin
            n_errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask

    task automatic wr(input logic [7:0] d, input logic exp);
        logic a;
        shp_host_model_i.write_byte(d, a);
        chk(a === exp, "acknowledge after written byte");
    endtask

    task automatic rd(input logic mack, input logic [7:0] exp);
        logic [7:0] d;
        shp_host_model_i.read_byte(mack, d);
        chk(d === exp, "read byte");
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_write_burst();
        shp_host_model_i.start_cond();
        wr(8'h9E, 1'b1);
        wr(8'h10, 1'b1);
        wr(8'hA5, 1'b1);
        wr(8'h5A, 1'b1);
        shp_host_model_i.stop_cond();
        chk(regs[16] === 8'hA5 && regs[17] === 8'h5A, "burst write");
    endtask

    task automatic t_read_zero();
        shp_host_model_i.start_cond();
        wr(8'h9F, 1'b1);
        rd(1'b1, 8'h3C);
        rd(1'b0, 8'hC3);
        shp_host_model_i.stop_cond();
        shp_host_model_i.wait_clk(8);
        chk(sda_oe === 1'b0, "data wire released");
    endtask

    task automatic t_preset_sat();
        shp_host_model_i.start_cond();
        wr(8'h9E, 1'b1);
        wr(8'hFE, 1'b1);
        shp_host_model_i.start_cond();
        wr(8'h9F, 1'b1);
        rd(1'b1, 8'hE1);
        rd(1'b1, 8'hF0);
        rd(1'b0, 8'hF0);
        shp_host_model_i.stop_cond();
    endtask

    task automatic t_strap();
        cs_n_pin <= 1'b1;
        shp_host_model_i.wait_clk(8);
        shp_host_model_i.start_cond();
        wr(8'h9E, 1'b0);
        shp_host_model_i.stop_cond();
        shp_host_model_i.start_cond();
        wr(8'hA0, 1'b1);
        wr(8'h20, 1'b1);
        wr(8'h77, 1'b1);
        shp_host_model_i.stop_cond();
        chk(regs[32] === 8'h77, "write at high strap");
        cs_n_pin <= 1'b0;
        shp_host_model_i.wait_clk(8);
    endtask

    task automatic t_early_stop();
        logic r;
        shp_host_model_i.start_cond();
        wr(8'h9E, 1'b1);
        repeat (3) shp_host_model_i.bit_xfer(1'b0, r);
        shp_host_model_i.stop_cond();
        chk(sda_oe === 1'b0, "released after early stop");
        shp_host_model_i.start_cond();
        wr(8'h9F, 1'b1);
        rd(1'b0, 8'h3C);
        shp_host_model_i.stop_cond();
    endtask

    task automatic t_spi();
        sel_pin <= 1'b0;
        shp_host_model_i.wait_clk(8);
        chk(spi_dout_oe === 1'b1 && spi_selected === 1'b1, "spi selected");
        chk(spi_dout === 1'b0, "spi data idle level");
        shp_host_model_i.start_cond();
        wr(8'h9E, 1'b0);
        shp_host_model_i.stop_cond();
        cs_n_pin <= 1'b1;
        shp_host_model_i.wait_clk(8);
        chk(spi_dout_oe === 1'b0 && spi_selected === 1'b0, "spi output off");
        cs_n_pin <= 1'b0;
        sel_pin <= 1'b1;
        shp_host_model_i.wait_clk(8);
    endtask

    // Reset lands while the device holds a data acknowledge low
    task automatic t_mid_reset();
        logic r;
        logic [7:0] d;
        d = 8'h11;
        shp_host_model_i.start_cond();
        wr(8'h9E, 1'b1);
        wr(8'h40, 1'b1);
        for (int i = 7; i >= 0; i--) shp_host_model_i.bit_xfer(d[i], r);
        chk(sda_oe === 1'b1 && sda_out === 1'b0, "ack pulls data low");
        chk(regs[64] === 8'h11, "write before reset");
        rst <= 1'b1;
        shp_host_model_i.wait_clk(2);
        rst <= 1'b0;
        shp_host_model_i.wait_clk(2);
        chk(sda_oe === 1'b0 && reg_addr === 8'h00, "state after mid-run reset");
        shp_host_model_i.stop_cond();
        shp_host_model_i.start_cond();
        wr(8'h9F, 1'b1);
        rd(1'b0, 8'h3C);
        shp_host_model_i.stop_cond();
    endtask

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        rst = 1'b1;
        sel_pin = 1'b1;
        cs_n_pin = 1'b0;
        for (int i = 0; i < 256; i++) regs[i] = 8'h00;
        regs[0] = 8'h3C;
        regs[1] = 8'hC3;
        regs[254] = 8'hE1;
        regs[255] = 8'hF0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        t_write_burst();
        t_read_zero();
        t_preset_sat();
        t_strap();
        t_early_stop();
        t_spi();
        t_mid_reset();
        tally_and_finish();
    end

    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
